//--- src/obc_decoder.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module obc_decoder (
    input wire logic pclk, // APB clock, 125 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic prog_mode_pin, // Programming mode pin
    output logic nv_req, // Storage request, held to ack
    output logic nv_we, // Storage write when high
    output logic nv_addr, // Option byte index
    output logic [7:0] nv_wdata, // Storage write data
    input wire logic [7:0] nv_rdata, // Storage read data
    input wire logic nv_ack, // Storage done pulse
    output logic mem_erase_req, // Whole memory wipe, held
    input wire logic mem_erase_done, // Wipe done pulse
    output logic [7:0] mem_fill_value, // Erased memory value
    input wire logic halt_entry, // CPU enters halt, pulse
    input wire logic watchdog_sw_enable, // Software started watchdog
    output logic halt_reset_req, // Reset on halt, pulse
    output logic config_valid, // Option bytes loaded
    output obc_pkg::obc_clk_src_t startup_clock_select, // Start-up clock
    output obc_pkg::obc_lvd_t low_voltage_threshold_select, // Detector level
    output logic lvd_enable, // Detector on
    output logic watchdog_type_select, // 1: software watchdog
    output logic watchdog_hw_enable, // Watchdog forced on
    output logic watchdog_halt_reset_enable, // Halt reset option
    output logic wakeup_clock_select, // 1: wake-up RC
    output logic osc_range_valid, // Range field in use
    output obc_pkg::obc_osc_t oscillator_range_select, // Oscillator range
    output logic [12:0] sector0_size_bytes, // Sector 0 size
    output logic readout_protect, // Readout blocked
    output logic program_write_protect, // Memory locked
    output logic block_prog_write // Program writes refused
);
    typedef enum logic [3:0] {
        S_BOOT, S_LOAD0, S_LOAD1, S_IDLE, S_WRITE, S_MERASE, S_ERASE0, S_ERASE1,
        S_DONE
    } obc_state_t;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    obc_state_t state_reg;
    obc_state_t state_next;
    logic [7:0] cfg0_reg;
    logic [7:0] cfg0_next;
    logic [7:0] cfg1_reg;
    logic [7:0] cfg1_next;
    logic [7:0] shd0_reg;
    logic [7:0] shd0_next;
    logic [7:0] shd1_reg;
    logic [7:0] shd1_next;
    logic loaded_reg;
    logic loaded_next;
    logic addr_reg;
    logic addr_next;
    logic [7:0] wdata_reg;
    logic [7:0] wdata_next;
    logic erase_reg;
    logic erase_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic halt_rst_reg;
    logic halt_rst_next;

    logic prog_q;
    logic setup;
    logic acc;
    logic is_opt0;
    logic is_opt1;
    logic is_opt;
    logic is_ctrl;
    logic is_stat;
    logic locked;
    logic bad;
    logic nv_go;
    logic erase_go;
    logic start;
    logic wd_active;

    obc_cfg_if cfg_if ();

    // ------------------------------------------------------------
    // Programming mode pin and field decode
    // ------------------------------------------------------------
    obc_sync #(
        .WIDTH(1)
    ) u_prog_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(prog_mode_pin),
        .q(prog_q)
    );

    assign cfg_if.opt0 = cfg0_reg;
    assign cfg_if.opt1 = cfg1_reg;

    obc_field_decode u_decode (
        .cfg(cfg_if)
    );

    assign startup_clock_select = cfg_if.startup_clock_select;
    assign low_voltage_threshold_select = cfg_if.low_voltage_threshold_select;
    assign lvd_enable = cfg_if.lvd_enable;
    assign watchdog_type_select = cfg_if.watchdog_type_select;
    assign watchdog_hw_enable = cfg_if.watchdog_hw_enable;
    assign watchdog_halt_reset_enable = cfg_if.watchdog_halt_reset_enable;
    assign wakeup_clock_select = cfg_if.wakeup_clock_select;
    assign osc_range_valid = cfg_if.osc_range_valid;
    assign oscillator_range_select = cfg_if.oscillator_range_select;
    assign sector0_size_bytes = cfg_if.sector0_size_bytes;
    assign readout_protect = cfg_if.readout_protect;
    assign program_write_protect = cfg_if.program_write_protect;
    assign block_prog_write = cfg_if.block_prog_write;
    assign mem_fill_value = obc_pkg::MEM_FILL; // [R15]

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign is_opt0 = paddr == obc_pkg::ADDR_OPT0;
    assign is_opt1 = paddr == obc_pkg::ADDR_OPT1;
    assign is_opt = is_opt0 || is_opt1;
    assign is_ctrl = paddr == obc_pkg::ADDR_CTRL;
    assign is_stat = paddr == obc_pkg::ADDR_STAT;
    // Lock follows the stored byte, so it bites right after programming
    assign locked = shd0_reg[obc_pkg::O0_WP]; // [R14]
    assign bad = !(is_opt || is_ctrl || is_stat)
        || ((is_opt || is_ctrl) && !prog_q) // [R1]
        || (pwrite && (is_opt || is_ctrl) && locked); // [R14]
    assign nv_go = pwrite && is_opt;
    assign erase_go = pwrite && is_ctrl && pwdata[obc_pkg::CTRL_ERASE];
    assign start = state_reg == S_IDLE && acc && !bad && (nv_go || erase_go);
    assign pready = acc && ((state_reg == S_IDLE && !start) || state_reg == S_DONE);
    assign pslverr = pready && state_reg == S_IDLE && bad;
    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // Load, program and erase sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cfg0_next = cfg0_reg;
        cfg1_next = cfg1_reg;
        shd0_next = shd0_reg;
        shd1_next = shd1_reg;
        loaded_next = loaded_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        erase_next = erase_reg;
        unique case (state_reg)
            S_BOOT: begin
                state_next = S_LOAD0;
            end
            S_LOAD0: begin
                if (nv_ack) begin
                    cfg0_next = nv_rdata; // [R16]
                    shd0_next = nv_rdata;
                    addr_next = 1'b1;
                    state_next = S_LOAD1;
                end
            end
            S_LOAD1: begin
                if (nv_ack) begin
                    cfg1_next = nv_rdata; // [R16]
                    shd1_next = nv_rdata;
                    loaded_next = 1'b1;
                    state_next = S_IDLE;
                end
            end
            S_IDLE: begin
                if (start && nv_go) begin
                    addr_next = is_opt1;
                    wdata_next = pwdata[7:0];
                    erase_next = 1'b0;
                    state_next = S_WRITE;
                end else if (start) begin
                    addr_next = 1'b0;
                    wdata_next = obc_pkg::OPT0_ERASED; // [R17]
                    erase_next = 1'b1;
                    // Protected code must be gone before the bytes unlock
                    if (shd0_reg[obc_pkg::O0_RP]) begin // [R13]
                        state_next = S_MERASE;
                    end else begin
                        state_next = S_ERASE0;
                    end
                end
            end
            S_WRITE: begin
                if (nv_ack) begin
                    state_next = S_DONE;
                end
            end
            S_MERASE: begin
                if (mem_erase_done) begin
                    state_next = S_ERASE0; // [R13]
                end
            end
            S_ERASE0: begin
                if (nv_ack) begin
                    addr_next = 1'b1;
                    wdata_next = obc_pkg::OPT1_ERASED; // [R17]
                    state_next = S_ERASE1;
                end
            end
            S_ERASE1: begin
                if (nv_ack) begin
                    state_next = S_DONE;
                end
            end
            S_DONE: begin
                // Only the stored copy changes; live fields wait for reset
                if (erase_reg) begin
                    shd0_next = obc_pkg::OPT0_ERASED; // [R17]
                    shd1_next = obc_pkg::OPT1_ERASED;
                end else if (addr_reg) begin
                    shd1_next = wdata_reg;
                end else begin
                    shd0_next = wdata_reg;
                end
                state_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_BOOT;
            cfg0_reg <= obc_pkg::OPT0_ERASED; // [R17]
            cfg1_reg <= obc_pkg::OPT1_ERASED;
            shd0_reg <= obc_pkg::OPT0_ERASED;
            shd1_reg <= obc_pkg::OPT1_ERASED;
            loaded_reg <= 1'b0;
            addr_reg <= 1'b0;
            wdata_reg <= 8'h00;
            erase_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cfg0_reg <= cfg0_next;
            cfg1_reg <= cfg1_next;
            shd0_reg <= shd0_next;
            shd1_reg <= shd1_next;
            loaded_reg <= loaded_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            erase_reg <= erase_next;
        end
    end

    assign nv_req = state_reg inside {S_LOAD0, S_LOAD1, S_WRITE, S_ERASE0, S_ERASE1};
    assign nv_we = state_reg inside {S_WRITE, S_ERASE0, S_ERASE1};
    assign nv_addr = addr_reg;
    assign nv_wdata = wdata_reg;
    assign mem_erase_req = state_reg == S_MERASE; // [R13]
    assign config_valid = loaded_reg;

    // ------------------------------------------------------------
    // Read data, captured in the setup phase
    // ------------------------------------------------------------
    always_comb begin
        prdata_next = prdata_reg;
        if (setup) begin
            prdata_next = 32'h0000_0000;
            if (is_opt0 && prog_q) begin // [R1]
                prdata_next[7:0] = shd0_reg;
            end else if (is_opt1 && prog_q) begin
                prdata_next[7:0] = shd1_reg;
            end else if (is_stat) begin
                prdata_next[obc_pkg::ST_LOADED] = loaded_reg;
                prdata_next[obc_pkg::ST_PROG] = prog_q;
                prdata_next[obc_pkg::ST_BUSY] = state_reg != S_IDLE;
                prdata_next[obc_pkg::ST_RP] = cfg0_reg[obc_pkg::O0_RP];
                prdata_next[obc_pkg::ST_WP] = cfg0_reg[obc_pkg::O0_WP];
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog reset on halt
    // ------------------------------------------------------------
    assign wd_active = cfg_if.watchdog_hw_enable || watchdog_sw_enable;

    always_comb begin
        halt_rst_next = halt_entry && wd_active && cfg1_reg[obc_pkg::O1_WATCHDOG_HALT_RESET_ENABLE]; // [R6]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            halt_rst_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            halt_rst_reg <= halt_rst_next;
        end
    end

    assign halt_reset_req = halt_rst_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence locked_write_s;
        acc && pwrite && is_opt && state_reg == S_IDLE;
    endsequence

    sequence ro_erase_s;
        start && erase_go && shd0_reg[obc_pkg::O0_RP];
    endsequence

    sequence load0_s;
        state_reg == S_LOAD0 && nv_ack;
    endsequence

    opt_prog_lock_a: assert property (locked_write_s and !prog_q |->
        pslverr ##1 ($stable(shd0_reg) && $stable(shd1_reg) && !nv_req)) // [R1]
        else $error("option write outside programming mode took effect");
    wp_lock_a: assert property (locked_write_s and shd0_reg[obc_pkg::O0_WP] |->
        pslverr ##1 (!nv_req && $stable(shd0_reg))) // [R14]
        else $error("write-protected option byte was modified");
    wipe_first_a: assert property (ro_erase_s |=>
        mem_erase_req && !nv_req ##1 !nv_we [*1]) // [R13]
        else $error("protected erase did not wipe memory first");
    load_order_a: assert property (load0_s |=>
        nv_req && !nv_we && nv_addr && !config_valid) // [R16]
        else $error("second option byte not fetched after first");
    live_hold_a: assert property (config_valid |=>
        $stable(cfg0_reg) && $stable(cfg1_reg) && config_valid) // [R16]
        else $error("live configuration changed after load");
    halt_reset_a: assert property (halt_entry && wd_active |=>
        halt_reset_req == $past(cfg1_reg[obc_pkg::O1_WATCHDOG_HALT_RESET_ENABLE])) // [R6]
        else $error("halt reset does not follow its option");
    hw_dog_a: assert property (!cfg1_reg[obc_pkg::O1_WDG_TYPE] |->
        watchdog_hw_enable && wd_active) // [R5]
        else $error("hardware watchdog not forced on");
    erase_value_a: assert property (state_reg == S_DONE && erase_reg |=>
        shd0_reg == obc_pkg::OPT0_ERASED && shd1_reg == obc_pkg::OPT1_ERASED) // [R17]
        else $error("erased option bytes hold wrong values");
    prot_block_a: assert property (cfg0_reg[obc_pkg::O0_RP] |->
        block_prog_write && readout_protect) // [R12]
        else $error("readout protection does not block writes");
    range_gate_a: assert property (osc_range_valid ==
        (startup_clock_select inside {obc_pkg::CLK_RESONATOR, obc_pkg::CLK_EXTERNAL})) // [R9]
        else $error("range field valid with internal start-up clock");
endmodule : obc_decoder

//--- src/obc_pkg.sv
package obc_pkg;
    // Notes on behaviour
    // R1: Option bytes accessible only in programming mode.
    // R2: Byte 1 bits 7:6 pick start-up clock.
    // R3: Programmer writes ones into byte 1 bits 5:4; option writes here store pwdata[5:4] as given.
    // R4: Byte 1 bits 3:2: 11 off, lower thresholds.
    // R5: Byte 1 bit 1 zero: watchdog hardware-enabled.
    // R6: Byte 1 bit 0 one: halt resets active watchdog.
    // R7: Byte 0 bit 7 picks wake-up timer clock.
    // R8: Wake-up bit zero needs range field 100.
    // R9: Range field decodes when start-up upper bit set.
    // R10: Internal RC start-up keeps default delay bits.
    // R11: Byte 0 bits 3:2 set sector 0 size.
    // R12: Byte 0 bit 1 blocks readout and writes.
    // R13: Protected erase wipes whole memory first.
    // R14: Write-protect bit locks memory and itself forever.
    // R15: Erased program memory reads FFh.
    // R16: Load bytes at reset, hold until reset.
    // R17: Erased bytes read FCh and 3Fh.

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OPT0 = 8'h00;
    localparam logic [7:0] ADDR_OPT1 = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam int CTRL_ERASE = 0;
    localparam int ST_LOADED = 0;
    localparam int ST_PROG = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_RP = 3;
    localparam int ST_WP = 4;

    // ------------------------------------------------------------
    // Option byte fields and values
    // ------------------------------------------------------------
    localparam int O1_CLK_HI = 7;
    localparam int O1_CLK_LO = 6;
    localparam int O1_LVD_HI = 3;
    localparam int O1_LVD_LO = 2;
    localparam int O1_WDG_TYPE = 1;
    localparam int O1_WATCHDOG_HALT_RESET_ENABLE = 0;
    localparam int O0_WAKE = 7;
    localparam int O0_OSC_HI = 6;
    localparam int O0_OSC_LO = 4;
    localparam int O0_SEC_HI = 3;
    localparam int O0_SEC_LO = 2;
    localparam int O0_RP = 1;
    localparam int O0_WP = 0;
    localparam logic [7:0] OPT0_ERASED = 8'hFC;
    localparam logic [7:0] OPT1_ERASED = 8'h3F;
    localparam logic [7:0] MEM_FILL = 8'hFF;
    localparam logic [1:0] LVD_OFF_CODE = 2'h3;
    localparam logic [12:0] SECTOR_UNIT = 13'h0200;

    typedef enum logic [1:0] {
        CLK_INT_RC, CLK_WAKE_RC, CLK_RESONATOR, CLK_EXTERNAL
    } obc_clk_src_t;
    typedef enum logic [1:0] {
        LVD_LOWEST, LVD_MEDIUM, LVD_HIGHEST, LVD_OFF
    } obc_lvd_t;
    typedef enum logic [2:0] {
        OSC_1_2MHZ, OSC_2_4MHZ, OSC_4_8MHZ, OSC_8_16MHZ, OSC_32K,
        OSC_MAIN_OSCILLATOR_PIN, OSC_RESERVED, OSC_PORT_B_PIN_ONE
    } obc_osc_t;
endpackage : obc_pkg

//--- src/obc_cfg_if.sv
`timescale 1ns/1ps
interface obc_cfg_if;
    logic [7:0] opt0;
    logic [7:0] opt1;
    obc_pkg::obc_clk_src_t startup_clock_select;
    obc_pkg::obc_lvd_t low_voltage_threshold_select;
    logic lvd_enable;
    logic watchdog_type_select;
    logic watchdog_hw_enable;
    logic watchdog_halt_reset_enable;
    logic wakeup_clock_select;
    logic osc_range_valid;
    obc_pkg::obc_osc_t oscillator_range_select;
    logic [12:0] sector0_size_bytes;
    logic readout_protect;
    logic program_write_protect;
    logic block_prog_write;

    modport src (
        output opt0, opt1,
        input startup_clock_select, low_voltage_threshold_select, lvd_enable,
        input watchdog_type_select, watchdog_hw_enable, watchdog_halt_reset_enable,
        input wakeup_clock_select, osc_range_valid, oscillator_range_select,
        input sector0_size_bytes, readout_protect, program_write_protect,
        input block_prog_write
    );
    modport dec (
        input opt0, opt1,
        output startup_clock_select, low_voltage_threshold_select, lvd_enable,
        output watchdog_type_select, watchdog_hw_enable, watchdog_halt_reset_enable,
        output wakeup_clock_select, osc_range_valid, oscillator_range_select,
        output sector0_size_bytes, readout_protect, program_write_protect,
        output block_prog_write
    );
endinterface : obc_cfg_if

//--- src/obc_sync.sv
`timescale 1ns/1ps
module obc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // Destination clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] d, // Level from another domain
    output logic [WIDTH-1:0] q // Level after two flops
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule : obc_sync

//--- src/obc_field_decode.sv
`timescale 1ns/1ps
module obc_field_decode (
    obc_cfg_if.dec cfg // Live option bytes in, fields out
);
    logic [1:0] sec;

    assign cfg.startup_clock_select = obc_pkg::obc_clk_src_t'(
        cfg.opt1[obc_pkg::O1_CLK_HI:obc_pkg::O1_CLK_LO]); // [R2]
    assign cfg.low_voltage_threshold_select = obc_pkg::obc_lvd_t'(
        cfg.opt1[obc_pkg::O1_LVD_HI:obc_pkg::O1_LVD_LO]); // [R4]
    assign cfg.lvd_enable = cfg.opt1[obc_pkg::O1_LVD_HI:obc_pkg::O1_LVD_LO]
        != obc_pkg::LVD_OFF_CODE; // [R4]
    assign cfg.watchdog_type_select = cfg.opt1[obc_pkg::O1_WDG_TYPE];
    assign cfg.watchdog_hw_enable = !cfg.opt1[obc_pkg::O1_WDG_TYPE]; // [R5]
    assign cfg.watchdog_halt_reset_enable = cfg.opt1[obc_pkg::O1_WATCHDOG_HALT_RESET_ENABLE]; // [R6]
    assign cfg.wakeup_clock_select = cfg.opt0[obc_pkg::O0_WAKE]; // [R7]
    // The range field means nothing while an internal RC starts the part
    assign cfg.osc_range_valid = cfg.opt1[obc_pkg::O1_CLK_HI]; // [R9]
    assign cfg.oscillator_range_select = obc_pkg::obc_osc_t'(
        cfg.opt0[obc_pkg::O0_OSC_HI:obc_pkg::O0_OSC_LO]); // [R9]
    assign sec = cfg.opt0[obc_pkg::O0_SEC_HI:obc_pkg::O0_SEC_LO];
    assign cfg.sector0_size_bytes = obc_pkg::SECTOR_UNIT << sec; // [R11]
    assign cfg.readout_protect = cfg.opt0[obc_pkg::O0_RP]; // [R12]
    assign cfg.program_write_protect = cfg.opt0[obc_pkg::O0_WP]; // [R14]
    assign cfg.block_prog_write = cfg.opt0[obc_pkg::O0_RP]
        || cfg.opt0[obc_pkg::O0_WP]; // [R12] [R14]
endmodule : obc_field_decode

//--- bench/obc_nv_model.sv
`timescale 1ns/1ps
module obc_nv_model (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic nv_req, // Request, held to ack
    input wire logic nv_we, // Write when high
    input wire logic nv_addr, // Byte index
    input wire logic [7:0] nv_wdata, // Write data
    output logic [7:0] nv_rdata, // Read data, valid with ack
    output logic nv_ack, // Done pulse
    input wire logic mem_erase_req, // Wipe request
    output logic mem_erase_done, // Wipe done pulse
    input wire logic [3:0] delay // Answer latency in cycles
);
    logic [7:0] mem [2];
    logic [3:0] cnt;
    // Stored bytes change only on a request from the decoder
    // No delay-select bits are kept here, so the default delay stays
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_ack <= 1'h0;
            mem_erase_done <= 1'h0;
            cnt <= 4'h0;
            nv_rdata <= 8'h5A;
        end else begin
            nv_ack <= 1'h0;
            mem_erase_done <= 1'h0;
            // Data goes stale off the ack cycle, so a late sample is caught
            nv_rdata <= ~nv_rdata;
            if ((nv_req && !nv_ack) || (mem_erase_req && !mem_erase_done)) begin
                cnt <= cnt + 4'h1;
                if (cnt >= delay) begin
                    cnt <= 4'h0;
                    nv_ack <= nv_req;
                    mem_erase_done <= mem_erase_req & !nv_req;
                    if (nv_req && nv_we) begin
                        mem[nv_addr] <= nv_wdata;
                    end
                    nv_rdata <= mem[nv_addr];
                end
            end
        end
    end
endmodule : obc_nv_model

//--- bench/option_byte_config_decoder_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module option_byte_config_decoder_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, prog_mode_pin = 0;
    logic halt_entry = 0, watchdog_sw_enable = 0, erased = 0;
    logic [7:0] paddr = 0, b0, b1, nv_wdata, nv_rdata, mem_fill_value;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0] delay = 0;
    logic [33:0] e;
    logic [33:0] q [$];
    logic [12:0] sector0_size_bytes;
    logic pready, pslverr, nv_req, nv_we, nv_addr, nv_ack, mem_erase_req, mem_erase_done;
    logic halt_reset_req, config_valid, lvd_enable, watchdog_type_select, watchdog_hw_enable;
    logic watchdog_halt_reset_enable, wakeup_clock_select, osc_range_valid;
    logic readout_protect, program_write_protect, block_prog_write;
    obc_pkg::obc_clk_src_t startup_clock_select;
    obc_pkg::obc_lvd_t low_voltage_threshold_select;
    obc_pkg::obc_osc_t oscillator_range_select;
    int n_fail = 0, tests_run = 0, cyc = 0;

    obc_decoder dut (.*);
    obc_nv_model nv (.*);

    always #4 pclk = ~pclk;

    // ------------------------------------------------------------
    // Answer watcher and hang guard
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
        if (mem_erase_req === 1'h1) erased <= 1'h1;
        if (psel && penable && pready === 1'h1) begin
            e = q.pop_front();
            `CHK("pslverr", e[32], pslverr)
            if (!e[33]) `CHK("prdata", e[31:0], prdata)
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, ed,
                       input logic ee);
        q.push_back({w, ee, ed});
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // Ready is taken at the same rising edge the watcher uses
        do @(posedge pclk);
        while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic boot(input logic [7:0] x0, x1);
        @(posedge pclk);
        nv.mem[0] = x0;
        nv.mem[1] = x1;
        delay <= 4'($urandom_range(3));
        presetn <= 1'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        while (config_valid !== 1'h1) @(posedge pclk);
        repeat (4) @(posedge pclk);
    endtask : boot

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    initial begin
        void'($urandom(32'hE68368B2));
        for (int i = 0; i < 8; i++) begin
            b1 = {i[1:0], 2'h3, i[2:1], 2'($urandom)};
            b0 = {i[2:0] != 3'h4 || 1'($urandom), i[2:0], i[1:0], i[0], 1'h0};
            boot(b0, b1);
            watchdog_sw_enable <= 1'($urandom);
            @(negedge pclk);
            `CHK("byte1", {b1[7:6], b1[3:2], b1[3:2] != 2'h3, b1[1], ~b1[1], b1[0], b1[7]},
                {startup_clock_select, low_voltage_threshold_select, lvd_enable,
                 watchdog_type_select, watchdog_hw_enable, watchdog_halt_reset_enable,
                 osc_range_valid})
            `CHK("byte0", {b0[7], b0[6:4], 13'h200 << b0[3:2], b0[1], b0[1], 1'h0, 8'hFF},
                {wakeup_clock_select, oscillator_range_select, sector0_size_bytes,
                 readout_protect, block_prog_write, program_write_protect,
                 mem_fill_value})
            @(posedge pclk) halt_entry <= 1'h1;
            @(posedge pclk) halt_entry <= 1'h0;
            @(negedge pclk);
            `CHK("halt", b1[0] & (~b1[1] | watchdog_sw_enable), halt_reset_req)
        end
        // Readout protected part: access gating, then an erase
        boot(8'hFE, 8'h3F);
        apb(1'h0, 8'h00, 32'h0, 32'h0, 1'h1);
        apb(1'h1, 8'h00, 32'hFC, 32'h0, 1'h1);
        prog_mode_pin <= 1'h1;
        repeat (4) @(posedge pclk);
        apb(1'h1, 8'h04, 32'h7B, 32'h0, 1'h0);
        apb(1'h0, 8'h04, 32'h0, 32'h7B, 1'h0);
        apb(1'h0, 8'h10, 32'h0, 32'h0, 1'h1);
        apb(1'h0, 8'h0C, 32'h0, 32'h0B, 1'h0);
        apb(1'h1, 8'h08, 32'h1, 32'h0, 1'h0);
        @(negedge pclk);
        `CHK("hold", 2'h0, startup_clock_select)
        `CHK("erase", {1'h1, 16'hFC3F}, {erased, nv.mem[0], nv.mem[1]})
        // Write protected part refuses every change
        boot(8'hFD, 8'h3F);
        apb(1'h1, 8'h00, 32'hFC, 32'h0, 1'h1);
        apb(1'h1, 8'h08, 32'h1, 32'h0, 1'h1);
        @(negedge pclk);
        `CHK("lock", {2'h3, 8'hFD}, {program_write_protect, block_prog_write, nv.mem[0]})
        report_and_stop();
    end
endmodule : option_byte_config_decoder_bench
